/* hdl/wdt_pkg.sv */
package wdt_pkg;
  // Register byte addresses on the Wishbone bus.
  localparam logic [3:0] WDT_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] WDT_ADDR_KEY = 4'h4;
  localparam logic [3:0] WDT_ADDR_CONFIG = 4'h8;
  localparam logic [3:0] WDT_ADDR_IRQ_STATUS = 4'hC;
  // Field positions of watchdog_control.
  localparam int WDT_BIT_RESTART = 0;
  localparam int WDT_BIT_RST_EN = 1;
  localparam int WDT_BIT_RST_CAUSE = 2;
  localparam int WDT_BIT_TIMEOUT = 3;
  localparam int WDT_BIT_POWERUP = 6;
  // Field positions of the config register.
  localparam int WDT_BIT_SEL_LO = 0;
  localparam int WDT_BIT_SEL_HI = 1;
  localparam int WDT_BIT_WD_IRQ_EN = 2;
  localparam int WDT_BIT_GLB_IRQ_EN = 3;
  localparam int WDT_BIT_RUN = 4;
  // Timed-access keys.
  localparam logic [7:0] WDT_KEY_FIRST = 8'hAA;
  localparam logic [7:0] WDT_KEY_SECOND = 8'h55;
  // Reset values.
  localparam logic [1:0] WDT_SEL_RESET = 2'h0;
  // Timing counts in system clocks and machine cycles.
  localparam int WDT_PENDING_CLOCKS = 512;
  localparam int WDT_UNLOCK_CLOCKS = 3;
  localparam int WDT_CLOCKS_PER_MC = 12;
  localparam int WDT_RESET_MCS = 2;
  localparam int WDT_RESET_CLOCKS = WDT_CLOCKS_PER_MC * WDT_RESET_MCS;
  // Interval exponents for select codes 0..3.
  localparam int WDT_EXP_BASE = 17;
  localparam int WDT_EXP_STEP = 3;
  localparam int WDT_CNT_W = 27;
endpackage

/* hdl/wdt_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_divider
  import wdt_pkg::*;
#(
  parameter int CNT_W = WDT_CNT_W,
  parameter int EXP_BASE = WDT_EXP_BASE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [1:0] sel_i,
  // Status
  output logic tick_o
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] limit;

  function automatic logic [CNT_W-1:0] wdt_limit(input logic [1:0] sel);
    int e;
    e = EXP_BASE + int'(sel) * WDT_EXP_STEP;
    wdt_limit = CNT_W'((64'd1 << e) - 64'd1);
  endfunction

  assign limit = wdt_limit(sel_i);
  assign cnt_d = cnt_q + CNT_W'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !run_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q == limit);
      cnt_q <= (cnt_q == limit) ? '0 : cnt_d;
    end
  end
endmodule
`default_nettype wire

/* hdl/wdt_reset_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_reset_gen
  import wdt_pkg::*;
#(
  parameter int PEND = WDT_PENDING_CLOCKS,
  parameter int PULSE = WDT_RESET_CLOCKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic arm_i,
  input wire logic cancel_i,
  input wire logic enable_i,
  // Status
  output logic fire_o,
  output logic sys_rst_o
);
  typedef enum logic [1:0] {WDT_IDLE, WDT_PEND, WDT_PULSE} wdt_state_t;
  wdt_state_t state_q;
  logic [9:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= WDT_IDLE;
      cnt_q <= '0;
      fire_o <= 1'b0;
      sys_rst_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      case (state_q)
        WDT_IDLE: begin
          if (arm_i && enable_i && !cancel_i) begin
            state_q <= WDT_PEND;
            cnt_q <= 10'(PEND - 1);
          end
        end
        WDT_PEND: begin
          if (cancel_i || !enable_i) begin
            state_q <= WDT_IDLE;
          end else if (cnt_q == '0) begin
            state_q <= WDT_PULSE;
            cnt_q <= 10'(PULSE - 1);
            fire_o <= 1'b1;
            sys_rst_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 10'd1;
          end
        end
        WDT_PULSE: begin
          if (cnt_q == '0) begin
            state_q <= WDT_IDLE;
            sys_rst_o <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 10'd1;
          end
        end
        default: begin
          state_q <= WDT_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* hdl/wdt_top.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_top
  import wdt_pkg::*;
#(
  parameter int CNT_W = WDT_CNT_W,
  parameter int EXP_BASE = WDT_EXP_BASE,
  parameter int PEND = WDT_PENDING_CLOCKS
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Watchdog outputs
  output logic wd_irq_req_o,
  output logic wd_sys_rst_o,
  output logic irq_o
);
  logic req;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic [1:0] key_q;
  logic [1:0] win_q;
  logic unlocked;
  logic sel_lo_q;
  logic sel_hi_q;
  logic wd_irq_enable_q;
  logic global_irq_enable_q;
  logic run_q;
  logic rst_en_q;
  logic timeout_q;
  logic cause_q;
  logic powerup_q;
  logic restart_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic tick;
  logic fire;
  logic sys_rst;
  logic wd_rst_seen_q;
  logic restart_now;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign wb = dat_i[7:0];
  assign unlocked = (win_q != 2'd0);

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  assign restart_now = restart_q || rst_i || wd_rst_seen_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i || rst_i) begin
      key_q <= 2'd0;
      win_q <= 2'd0;
    end else begin
      if (win_q != 2'd0) begin
        win_q <= win_q - 2'd1;
      end
      if (wr && hit(adr_i, WDT_ADDR_KEY)) begin
        if (wb == WDT_KEY_FIRST) begin
          key_q <= 2'd1;
        end else if (wb == WDT_KEY_SECOND && key_q == 2'd1) begin
          key_q <= 2'd0;
          win_q <= 2'(WDT_UNLOCK_CLOCKS);
        end else begin
          key_q <= 2'd0;
        end
      end else if (wr) begin
        key_q <= 2'd0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      run_q <= 1'b0;
      rst_en_q <= 1'b0;
      {sel_hi_q, sel_lo_q} <= WDT_SEL_RESET;
      wd_irq_enable_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
      irq_mask_q <= 2'd0;
    end else if (wr && hit(adr_i, WDT_ADDR_CONFIG)) begin
      sel_lo_q <= wb[WDT_BIT_SEL_LO];
      sel_hi_q <= wb[WDT_BIT_SEL_HI];
      wd_irq_enable_q <= wb[WDT_BIT_WD_IRQ_EN];
      global_irq_enable_q <= wb[WDT_BIT_GLB_IRQ_EN];
      run_q <= wb[WDT_BIT_RUN];
      irq_mask_q <= dat_i[9:8];
    end else if (wr && hit(adr_i, WDT_ADDR_CONTROL) && unlocked) begin
      rst_en_q <= wb[WDT_BIT_RST_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i || rst_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr && hit(adr_i, WDT_ADDR_CONTROL) && unlocked && wb[WDT_BIT_RESTART];
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      wd_rst_seen_q <= 1'b0;
    end else begin
      wd_rst_seen_q <= sys_rst;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      timeout_q <= 1'b0;
    end else if (tick) begin
      timeout_q <= 1'b1;
    end else if (wr && hit(adr_i, WDT_ADDR_CONTROL) && unlocked) begin
      timeout_q <= wb[WDT_BIT_TIMEOUT];
    end
  end

  // Cause flag set by watchdog reset.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cause_q <= 1'b0;
    end else if (fire) begin
      cause_q <= 1'b1;
    end else if (wr && hit(adr_i, WDT_ADDR_CONTROL) && !wb[WDT_BIT_RST_CAUSE]) begin
      cause_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      powerup_q <= 1'b1;
    end else if (wr && hit(adr_i, WDT_ADDR_CONTROL)) begin
      powerup_q <= wb[WDT_BIT_POWERUP];
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      wd_irq_req_o <= 1'b0;
    end else begin
      wd_irq_req_o <= timeout_q && wd_irq_enable_q && global_irq_enable_q;
    end
  end

  // Status bits: 0 timeout, 1 watchdog reset; a read clears them.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      irq_stat_q <= 2'd0;
    end else begin
      irq_stat_q <= (rd && hit(adr_i, WDT_ADDR_IRQ_STATUS) ? 2'd0 : irq_stat_q) | {fire, tick};
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      wd_sys_rst_o <= 1'b0;
    end else begin
      wd_sys_rst_o <= sys_rst;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i || rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (adr_i)
        WDT_ADDR_CONTROL: begin
          dat_o <= {24'h00_0000, 1'b0, powerup_q, 2'b00, timeout_q, cause_q, rst_en_q, restart_q};
        end
        WDT_ADDR_KEY: begin
          dat_o <= {30'h0000_0000, key_q};
        end
        WDT_ADDR_CONFIG: begin
          dat_o <= {22'h00_0000, irq_mask_q, 3'b000, run_q, global_irq_enable_q,
                    wd_irq_enable_q, sel_hi_q, sel_lo_q};
        end
        WDT_ADDR_IRQ_STATUS: begin
          dat_o <= {30'h0000_0000, irq_stat_q};
        end
        default: begin
          dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  wdt_divider #(
    .CNT_W(CNT_W),
    .EXP_BASE(EXP_BASE)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(por_i),
    .run_i(run_q),
    .clear_i(restart_now),
    .sel_i({sel_hi_q, sel_lo_q}),
    .tick_o(tick)
  );

  wdt_reset_gen #(
    .PEND(PEND)
  ) u_rst (
    .clk_i(clk_i),
    .rst_i(por_i),
    .arm_i(tick),
    .cancel_i(restart_now),
    .enable_i(rst_en_q),
    .fire_o(fire),
    .sys_rst_o(sys_rst)
  );
endmodule
`default_nettype wire

/* bench/wdt_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_checker
  import wdt_pkg::*;
#(
  parameter int CNT_W = WDT_CNT_W,
  parameter int EXP_BASE = WDT_EXP_BASE,
  parameter int PEND = WDT_PENDING_CLOCKS
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Watchdog outputs
  input wire logic wd_irq_req_o,
  input wire logic wd_sys_rst_o,
  input wire logic irq_o
);
  logic [9:0] cfg_q;
  logic [5:0] hi_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (por_i || rst_i);
  // Shadow of the config register, so gating can be judged from the ports alone.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cfg_q <= '0;
    end else if (ack_o && we_i && sel_i[0] && adr_i == WDT_ADDR_CONFIG) begin
      cfg_q <= dat_i[9:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (por_i || !wd_sys_rst_o) begin
      hi_q <= '0;
    end else begin
      hi_q <= hi_q + 6'h1;
    end
  end
  chk_ack_resp: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_irq_gate: assert property ((!(cfg_q[2] && cfg_q[3]))[*3] |-> !wd_irq_req_o)
    else $error("watchdog request without both enables");
  chk_irq_mask: assert property ((cfg_q[9:8] == 2'h0)[*3] |-> !irq_o)
    else $error("interrupt with all sources masked");
  chk_rst_len: assert property ($fell(wd_sys_rst_o) |-> hi_q == WDT_RESET_CLOCKS)
    else $error("system reset pulse has wrong length");
  chk_por_quiet: assert property (disable iff (rst_i) por_i |=> !wd_sys_rst_o && !wd_irq_req_o && !irq_o)
    else $error("outputs active after power-on reset");
  chk_unmapped_rd: assert property (ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_restart_rd: assert property (ack_o && !we_i && adr_i == WDT_ADDR_CONTROL |-> !dat_o[WDT_BIT_RESTART])
    else $error("restart bit reads back set");
endmodule
bind wdt_top wdt_checker #(.CNT_W(CNT_W), .EXP_BASE(EXP_BASE), .PEND(PEND)) i_wdt_checker (.clk_i(clk_i),
  .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wd_irq_req_o(wd_irq_req_o), .wd_sys_rst_o(wd_sys_rst_o),
  .irq_o(irq_o));
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import wdt_pkg::*;
  localparam int EB = 4;
  localparam int PD = 8;
  logic clk_i = 0, rst_i = 1, por_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, saw_rst = 0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
  logic ack_o, wd_irq_req_o, wd_sys_rst_o, irq_o;
  int n_errors = 0, cmp_count = 0, n;
  integer seed = 32'h391e_d504;
  wdt_top #(.EXP_BASE(EB), .PEND(PD)) i_wdt_top (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .wd_irq_req_o(wd_irq_req_o), .wd_sys_rst_o(wd_sys_rst_o), .irq_o(irq_o));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (wd_sys_rst_o === 1'b1) saw_rst <= 1'b1;
  function automatic int per(input int s);
    return 1 << (EB + WDT_EXP_STEP * s);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Called just after a rising edge; ack and read data are taken at the edge that samples ack high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    if (t >= 20) chk(1, 0);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic kw(input logic [31:0] d);
    wb(1, WDT_ADDR_KEY, {24'h00_0000, WDT_KEY_FIRST});
    wb(1, WDT_ADDR_KEY, {24'h00_0000, WDT_KEY_SECOND});
    wb(1, WDT_ADDR_CONTROL, d);
  endtask
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (wd_sys_rst_o !== lvl && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    por_i <= 0;
    @(posedge clk_i);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd, 32'h0000_0040);
    wb(0, WDT_ADDR_CONFIG, 0);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      n = $random(seed);
      wb(1, WDT_ADDR_CONTROL, n & 32'h0000_00FF);
      wb(0, WDT_ADDR_CONTROL, 0);
      chk(rd, n & 32'h0000_0040);
      wb(0, {n[11:10], n[9:8] | 2'h1}, 0);
    end
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wb(1, WDT_ADDR_CONFIG, 32'h0000_0110 | s);
      kw(32'h0000_0001);
      wb(0, WDT_ADDR_IRQ_STATUS, 0);
      n = 0;
      while (irq_o !== 1'b1 && n < 9000) begin
        @(negedge clk_i);
        n++;
      end
      @(posedge clk_i);
      chk(n > per(s) - 12 && n < per(s) + 4, 1);
      wb(0, WDT_ADDR_CONTROL, 0);
      chk(rd[WDT_BIT_TIMEOUT], 1);
    end
    wb(1, WDT_ADDR_CONFIG, 32'h0000_0014);
    repeat (3) @(negedge clk_i);
    chk(wd_irq_req_o, 0);
    chk(irq_o, 0);
    wb(1, WDT_ADDR_CONFIG, 32'h0000_001C);
    repeat (3) @(negedge clk_i);
    chk(wd_irq_req_o, 1);
    @(posedge clk_i);
    $display("test intervals done");
    wb(1, WDT_ADDR_KEY, {24'h00_0000, WDT_KEY_FIRST});
    wb(1, WDT_ADDR_CONFIG, 32'h0000_001C);
    wb(1, WDT_ADDR_KEY, {24'h00_0000, WDT_KEY_SECOND});
    wb(1, WDT_ADDR_CONTROL, 32'h0000_0002);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd[WDT_BIT_RST_EN], 0);
    wb(1, WDT_ADDR_KEY, {24'h00_0000, WDT_KEY_FIRST});
    wb(1, WDT_ADDR_KEY, {24'h00_0000, WDT_KEY_SECOND});
    repeat (4) @(posedge clk_i);
    wb(1, WDT_ADDR_CONTROL, 32'h0000_0002);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd[WDT_BIT_RST_EN], 0);
    $display("test key done");
    kw(32'h0000_0003);
    wait_rst(1'b1);
    chk(n >= per(0) + PD - 12 && n <= per(0) + PD + 6, 1);
    wait_rst(1'b0);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd[WDT_BIT_RST_CAUSE], 1);
    kw(32'h0000_0005);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd[WDT_BIT_RST_CAUSE], 1);
    wb(1, WDT_ADDR_CONTROL, 0);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd[WDT_BIT_RST_CAUSE], 0);
    saw_rst = 0;
    // Restarts land after each time-out but before the pending reset runs out.
    for (int i = 0; i < 6; i++) begin
      kw(32'h0000_0003);
      repeat (11) @(posedge clk_i);
    end
    kw(32'h0000_0001);
    chk(saw_rst, 0);
    $display("test reset path done");
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, WDT_ADDR_CONFIG, 0);
    chk(rd, 32'h0000_001C);
    por_i <= 1;
    @(posedge clk_i);
    por_i <= 0;
    @(posedge clk_i);
    wb(0, WDT_ADDR_CONTROL, 0);
    chk(rd, 32'h0000_0040);
    wb(0, WDT_ADDR_CONFIG, 0);
    chk(rd, 32'h0000_0000);
    $display("test resets done");
    finish_test;
  end
endmodule
`default_nettype wire
